// *** rtl/i2cms_top.sv ***
// Two-wire bus master with abort-cause flags and programmable data set-up,
// registers on AXI4-Lite (MCLK), bus engine on the link clock.
// Assumes open-drain pins resolved outside and pull-ups on both wires.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "i2cms_consts.svh"
module i2cms_top (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic LINK_CLK,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic BUS_CLOCK_PIN_IN,
  output logic BUS_CLOCK_PIN_OUT,
  output logic BUS_CLOCK_PIN_OE_N,
  input wire logic BUS_DATA_PIN_IN,
  output logic BUS_DATA_PIN_OUT,
  output logic BUS_DATA_PIN_OE_N
);
  import i2cms_pkg::*;

  i2cms_mstate_t m_q;
  i2cms_mstate_t m_d;
  i2cms_lkstate_t l_q;
  i2cms_lkstate_t l_d;
  logic lrst_s1_q;
  logic lrst_n_q;
  logic tmr_expired;

  //////////////////////////////////////////////////////////////////////////
  // Register access helpers

  function automatic logic [32:0] read_reg(input i2cms_mstate_t s,
                                           input logic [7:0] a);
    logic [31:0] w;
    logic ok;
    w = 32'h0000_0000;
    ok = 1'b1;
    case (a)
      `I2CMS_OFF_CTRL: w = 32'h0000_0000;
      `I2CMS_OFF_TARGET: begin
        w[9:0] = s.addr;
        w[`I2CMS_TGT_TEN_BIT] = s.ten;
        w[`I2CMS_TGT_GCALL_BIT] = s.gc;
      end
      `I2CMS_OFF_DATA: begin
        w[7:0] = s.txd;
        w[`I2CMS_DATA_READ_BIT] = s.rdcmd;
      end
      `I2CMS_OFF_STATUS: begin
        w[`I2CMS_STAT_BUSY_BIT] = s.busy;
        w[`I2CMS_STAT_DONE_BIT] = s.done;
        w[`I2CMS_STAT_ABORT_BIT] = |s.cause; // [RQ10]
        w[`I2CMS_STAT_RX_LSB +: 8] = s.rx;
      end
      `I2CMS_OFF_ABORT: w[5:0] = s.cause; // [RQ7]
      `I2CMS_OFF_SETUP: w[7:0] = s.setup; // [RQ9]
      default: ok = 1'b0;
    endcase
    return {ok, w};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register domain (MCLK)

  logic [32:0] rd_word;
  logic [32:0] wr_old;
  logic [31:0] wr_val;

  assign rd_word = read_reg(m_q, S_AXI_ARADDR);
  assign wr_old = read_reg(m_q, m_q.awaddr);
  assign wr_val = merge(wr_old[31:0], m_q.wdata, m_q.wstrb);

  assign S_AXI_AWREADY = !m_q.aw_got && !m_q.bvalid;
  assign S_AXI_WREADY = !m_q.w_got && !m_q.bvalid;
  assign S_AXI_ARREADY = !m_q.rvalid;
  assign S_AXI_BVALID = m_q.bvalid;
  assign S_AXI_BRESP = m_q.bresp;
  assign S_AXI_RVALID = m_q.rvalid;
  assign S_AXI_RDATA = m_q.rdata;
  assign S_AXI_RRESP = m_q.rresp;

  always_comb begin
    m_d = m_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      m_d.aw_got = 1'b1;
      m_d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      m_d.w_got = 1'b1;
      m_d.wdata = S_AXI_WDATA;
      m_d.wstrb = S_AXI_WSTRB;
    end
    if (m_q.bvalid && S_AXI_BREADY) begin
      m_d.bvalid = 1'b0;
    end
    // Transfer end from the link: results are stable once the toggle lands
    m_d.dn_s1 = l_q.done_tgl;
    m_d.dn_s2 = m_q.dn_s1;
    m_d.dn_s3 = m_q.dn_s2;
    if (m_q.dn_s2 != m_q.dn_s3) begin
      m_d.busy = 1'b0;
      m_d.done = 1'b1;
      m_d.cause = l_q.cause; // [RQ10]
      m_d.rx = l_q.rx;
    end
    if (m_q.aw_got && m_q.w_got && !m_q.bvalid) begin
      m_d.aw_got = 1'b0;
      m_d.w_got = 1'b0;
      m_d.bvalid = 1'b1;
      m_d.bresp = wr_old[32] ? `I2CMS_RESP_OKAY : `I2CMS_RESP_SLVERR;
      // Settings are frozen while a transfer runs so the link may sample them
      if (!m_q.busy) begin
        case (m_q.awaddr)
          `I2CMS_OFF_CTRL: begin
            if (m_q.wstrb[0] && m_q.wdata[`I2CMS_CTRL_START_BIT]) begin
              m_d.start_tgl = !m_q.start_tgl;
              m_d.busy = 1'b1;
              m_d.done = 1'b0;
              m_d.cause = 6'h00;
            end
          end
          `I2CMS_OFF_TARGET: begin
            m_d.addr = wr_val[9:0];
            m_d.ten = wr_val[`I2CMS_TGT_TEN_BIT];
            m_d.gc = wr_val[`I2CMS_TGT_GCALL_BIT];
          end
          `I2CMS_OFF_DATA: begin
            m_d.txd = wr_val[7:0];
            m_d.rdcmd = wr_val[`I2CMS_DATA_READ_BIT];
          end
          `I2CMS_OFF_SETUP: m_d.setup = wr_val[7:0]; // [RQ9]
          default: m_d.bvalid = 1'b1;
        endcase
      end
    end
    if (m_q.rvalid && S_AXI_RREADY) begin
      m_d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      m_d.rvalid = 1'b1;
      m_d.rdata = rd_word[31:0];
      m_d.rresp = rd_word[32] ? `I2CMS_RESP_OKAY : `I2CMS_RESP_SLVERR;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      m_q <= '0;
      m_q.setup <= `I2CMS_SETUP_RST; // [RQ9]
    end else begin
      m_q <= m_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link domain reset: asserted at once, released on the link clock

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lrst_s1_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n_q <= lrst_s1_q;
    end
  end

  i2cms_setup_timer u_setup_timer (
    .clk(LINK_CLK),
    .rst_n(lrst_n_q),
    .load(l_q.ld),
    .count(l_q.setup),
    .expired(tmr_expired)
  );

  //////////////////////////////////////////////////////////////////////////
  // Bus engine (LINK_CLK)

  always_comb begin
    l_d = l_q;
    l_d.ld = 1'b0;
    l_d.st_s1 = m_q.start_tgl;
    l_d.st_s2 = l_q.st_s1;
    l_d.st_s3 = l_q.st_s2;
    l_d.scl_s1 = BUS_CLOCK_PIN_IN;
    l_d.scl_s2 = l_q.scl_s1;
    l_d.sda_s1 = BUS_DATA_PIN_IN;
    l_d.sda_s2 = l_q.sda_s1;
    if (l_q.cnt != 4'h0) begin
      l_d.cnt = l_q.cnt - 4'h1;
    end
    case (l_q.state)
      L_IDLE: begin
        if (l_q.st_s2 != l_q.st_s3) begin
          l_d.addr = m_q.addr;
          l_d.ten = m_q.ten;
          l_d.gc = m_q.gc;
          l_d.data = m_q.txd;
          l_d.rd = m_q.rdcmd;
          l_d.setup = m_q.setup;
          l_d.cause = 6'h00;
          l_d.rx = 8'h00;
          l_d.phase = PH_ADDR1;
          l_d.bit_cnt = 4'h0;
          if (m_q.gc && m_q.rdcmd) begin
            l_d.cause[`I2CMS_AB_GC_READ] = 1'b1; // [RQ1]
            l_d.done_tgl = !l_q.done_tgl; // [RQ10]
          end else begin
            if (m_q.ten) begin
              l_d.shreg = {`I2CMS_WIDE_PREFIX, m_q.addr[9:8], 1'b0, 1'b1};
            end else if (m_q.gc) begin
              l_d.shreg = {`I2CMS_GCALL_ADDR, 1'b1};
            end else begin
              l_d.shreg = {m_q.addr[6:0], m_q.rdcmd, 1'b1};
            end
            l_d.sda_o = 1'b0;
            l_d.cnt = `I2CMS_BUS_HIGH_CYC;
            l_d.state = L_START;
          end
        end
      end
      L_START: begin
        if (l_q.cnt == 4'h0) begin
          l_d.scl_o = 1'b0;
          l_d.state = L_DRIVE;
        end
      end
      L_DRIVE: begin
        l_d.sda_o = l_q.shreg[8];
        l_d.ld = 1'b1;
        l_d.state = L_SETUP;
      end
      L_SETUP: begin
        if (tmr_expired) begin
          l_d.scl_o = 1'b1; // [RQ8]
          l_d.cnt = `I2CMS_BUS_HIGH_CYC;
          l_d.state = L_HIGH;
        end
      end
      L_HIGH: begin
        // Hold the count while a slave stretches the clock low
        if (!l_q.scl_s2) begin
          l_d.cnt = l_q.cnt;
        end else if (l_q.cnt == 4'h0) begin
          l_d.scl_o = 1'b0;
          l_d.state = L_DRIVE;
          if (l_q.bit_cnt != 4'h8) begin
            if (l_q.phase == PH_DATA && l_q.rd) begin
              l_d.rx = {l_q.rx[6:0], l_q.sda_s2};
            end
            l_d.shreg = {l_q.shreg[7:0], 1'b1};
            l_d.bit_cnt = l_q.bit_cnt + 4'h1;
          end else begin
            l_d.bit_cnt = 4'h0;
            if (l_q.phase == PH_DATA) begin
              if (!l_q.rd && l_q.sda_s2) begin
                l_d.cause[`I2CMS_AB_DATA] = 1'b1; // [RQ3]
              end
              l_d.state = L_STOP_A;
            end else if (l_q.sda_s2) begin
              if (l_q.phase == PH_ADDR2) begin
                l_d.cause[`I2CMS_AB_WIDE2] = 1'b1; // [RQ4]
              end else if (l_q.ten) begin
                l_d.cause[`I2CMS_AB_WIDE1] = 1'b1; // [RQ5]
              end else if (l_q.gc) begin
                l_d.cause[`I2CMS_AB_GC_NACK] = 1'b1; // [RQ2]
              end else begin
                l_d.cause[`I2CMS_AB_SHORT] = 1'b1; // [RQ6]
              end
              l_d.state = L_STOP_A; // [RQ10]
            end else if (l_q.phase == PH_ADDR1 && l_q.ten) begin
              l_d.phase = PH_ADDR2;
              l_d.shreg = {l_q.addr[7:0], 1'b1};
            end else begin
              l_d.phase = PH_DATA;
              // A read releases the line for eight bits, then answers NACK
              l_d.shreg = l_q.rd ? 9'h1ff : {l_q.data, 1'b1};
            end
          end
        end
      end
      L_STOP_A: begin
        l_d.sda_o = 1'b0;
        l_d.ld = 1'b1;
        l_d.state = L_STOP_B;
      end
      L_STOP_B: begin
        if (tmr_expired) begin
          l_d.scl_o = 1'b1;
          l_d.cnt = `I2CMS_BUS_HIGH_CYC;
          l_d.state = L_STOP_C;
        end
      end
      L_STOP_C: begin
        if (!l_q.scl_s2) begin
          l_d.cnt = l_q.cnt;
        end else if (l_q.cnt == 4'h0) begin
          l_d.sda_o = 1'b1;
          l_d.done_tgl = !l_q.done_tgl; // [RQ10]
          l_d.state = L_IDLE;
        end
      end
      default: l_d.state = L_IDLE;
    endcase
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      l_q <= '0;
      l_q.state <= L_IDLE;
      l_q.scl_o <= 1'b1;
      l_q.sda_o <= 1'b1;
      l_q.scl_s1 <= 1'b1;
      l_q.scl_s2 <= 1'b1;
      l_q.sda_s1 <= 1'b1;
      l_q.sda_s2 <= 1'b1;
      l_q.setup <= `I2CMS_SETUP_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // Open drain: pull low with enable low, release with enable high
  assign BUS_CLOCK_PIN_OUT = 1'b0;
  assign BUS_DATA_PIN_OUT = 1'b0;
  assign BUS_CLOCK_PIN_OE_N = l_q.scl_o;
  assign BUS_DATA_PIN_OE_N = l_q.sda_o;

endmodule // i2cms_top
`default_nettype wire

// *** include/i2cms_consts.svh ***
// Offsets, field positions, reset values and timing counts of the
// two-wire master abort and data set-up block.
// Assumes a 32-bit AXI4-Lite register space and byte addresses.
//
// Notes on behaviour
// (RQ1) A general call whose following queued command is a read sets the general-call-read abort flag.
// (RQ2) A general call address that no slave acknowledges sets the general-call-unacked abort flag.
// (RQ3) A written data byte left unacknowledged after an acknowledged address sets the data-unacked flag.
// (RQ4) In wide (10-bit) addressing an unacknowledged second address byte sets the second-byte flag.
// (RQ5) In wide (10-bit) addressing an unacknowledged first address byte sets the first-byte flag.
// (RQ6) In short (7-bit) addressing an unacknowledged address sets the short-address flag.
// (RQ7) The abort-cause flags are read-only, reset to zero, and bit 6 reads as zero.
// (RQ8) The bus clock rising edge follows a data-line change by the programmed set-up count; the code waits that count plus two link clock cycles.
// (RQ9) The set-up register holds an 8-bit read/write field reset to 100, upper bits read zero.
// (RQ10) Any abort flag ends the transfer with a stop and raises an abort event for software; a general-call read ends before any start, with no stop.
`ifndef I2CMS_CONSTS_SVH
`define I2CMS_CONSTS_SVH

`define I2CMS_OFF_CTRL 8'h70
`define I2CMS_OFF_TARGET 8'h74
`define I2CMS_OFF_DATA 8'h78
`define I2CMS_OFF_STATUS 8'h7c
`define I2CMS_OFF_ABORT 8'h80
`define I2CMS_OFF_SETUP 8'h94

`define I2CMS_CTRL_START_BIT 0
`define I2CMS_TGT_TEN_BIT 12
`define I2CMS_TGT_GCALL_BIT 13
`define I2CMS_DATA_READ_BIT 8
`define I2CMS_STAT_BUSY_BIT 0
`define I2CMS_STAT_DONE_BIT 1
`define I2CMS_STAT_ABORT_BIT 2
`define I2CMS_STAT_RX_LSB 8

`define I2CMS_AB_SHORT 0
`define I2CMS_AB_WIDE1 1
`define I2CMS_AB_WIDE2 2
`define I2CMS_AB_DATA 3
`define I2CMS_AB_GC_NACK 4
`define I2CMS_AB_GC_READ 5

`define I2CMS_SETUP_RST 8'h64
`define I2CMS_WIDE_PREFIX 5'h1e
`define I2CMS_GCALL_ADDR 8'h00
`define I2CMS_BUS_HIGH_CYC 4'h4
`define I2CMS_RESP_OKAY 2'h0
`define I2CMS_RESP_SLVERR 2'h2

`endif

// *** include/i2cms_pkg.sv ***
// Types of the two-wire master abort and data set-up block.
// Assumes nothing beyond a SystemVerilog compiler.
package i2cms_pkg;

  typedef enum logic [2:0] {
    L_IDLE, L_START, L_DRIVE, L_SETUP, L_HIGH, L_STOP_A, L_STOP_B, L_STOP_C
  } i2cms_lstate_t;

  typedef enum logic [1:0] {PH_ADDR1, PH_ADDR2, PH_DATA} i2cms_phase_t;

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [9:0] addr;
    logic ten;
    logic gc;
    logic [7:0] txd;
    logic rdcmd;
    logic [7:0] setup;
    logic start_tgl;
    logic busy;
    logic done;
    logic [5:0] cause;
    logic [7:0] rx;
    logic dn_s1;
    logic dn_s2;
    logic dn_s3;
  } i2cms_mstate_t;

  typedef struct packed {
    i2cms_lstate_t state;
    i2cms_phase_t phase;
    logic [3:0] bit_cnt;
    logic [8:0] shreg;
    logic [3:0] cnt;
    logic rd;
    logic ten;
    logic gc;
    logic [9:0] addr;
    logic [7:0] data;
    logic [7:0] rx;
    logic [5:0] cause;
    logic [7:0] setup;
    logic done_tgl;
    logic scl_o;
    logic sda_o;
    logic ld;
    logic st_s1;
    logic st_s2;
    logic st_s3;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
  } i2cms_lkstate_t;

  typedef struct packed {
    logic [7:0] cnt;
  } i2cms_tstate_t;

endpackage : i2cms_pkg

// *** rtl/i2cms_setup_timer.sv ***
// Data set-up timer: counts link clock periods after a data-line change.
// Assumes load is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module i2cms_setup_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] count,
  output logic expired
);
  import i2cms_pkg::*;

  i2cms_tstate_t t_q;
  i2cms_tstate_t t_d;

  always_comb begin
    t_d = t_q;
    if (load) begin
      t_d.cnt = count; // [RQ8]
    end else if (t_q.cnt != 8'h00) begin
      t_d.cnt = t_q.cnt - 8'h01;
    end
  end

  assign expired = !load && (t_q.cnt == 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end
endmodule // i2cms_setup_timer
`default_nettype wire

// *** bench/i2cms_asserts.sv ***
// Concurrent checks on the register bus and wire enables of i2cms_top.
// Bound from tb_top; sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "i2cms_consts.svh"
module i2cms_asserts (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic LINK_CLK,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic BUS_CLOCK_PIN_OE_N,
  input wire logic BUS_DATA_PIN_OE_N
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
    S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("no bvalid");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID) else $error("no rvalid");
  a_write_blocked: assert property (S_AXI_BVALID
    |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write not blocked");
  a_read_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read not blocked");
  a_setup_upper: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `I2CMS_OFF_SETUP
    |=> S_AXI_RDATA[31:8] == 24'h0) else $error("setup upper bits set");
  a_cause_upper: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `I2CMS_OFF_ABORT
    |=> S_AXI_RDATA[31:6] == 26'h0) else $error("cause upper bits set");
  a_data_settled: assert property (
    @(posedge LINK_CLK) disable iff (!RESET_N) $rose(BUS_CLOCK_PIN_OE_N)
    |-> $stable(BUS_DATA_PIN_OE_N)) else $error("data moved at clock rise");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_cause_read: cover property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR == `I2CMS_OFF_ABORT);
  c_clock_rise: cover property (@(posedge LINK_CLK) $rose(BUS_CLOCK_PIN_OE_N));
endmodule // i2cms_asserts
`default_nettype wire

// *** bench/i2cms_slave_model.sv ***
// Remote two-wire slave: acknowledges byte n of a frame if ack_mask[n],
// and answers a read with READ_BYTE in the byte after the address.
// Assumes pull-ups outside; leaves the data wire released otherwise.
`timescale 1ns/1ps
`default_nettype none
module i2cms_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [3:0] ack_mask,
  output logic sda_oe_n
);
  // Byte returned to a read; the bench expects this value
  localparam logic [7:0] READ_BYTE = 8'h3c;
  int bit_n = 0;
  int byte_n = 0;
  logic rw = 1'b0;
  initial sda_oe_n = 1'b1;
  ////////////////////////////////////////
  // Start condition restarts the frame count
  always @(negedge sda) if (scl) begin
    bit_n = 0;
    byte_n = 0;
    rw = 1'b0;
  end
  // Direction bit is the eighth bit of the first byte
  always @(posedge scl) begin
    bit_n++;
    if (byte_n == 0 && bit_n == 8) rw = sda;
  end
  // Ack on the ninth clock; read data bits change while the clock is low
  always @(negedge scl) begin
    if (bit_n == 9) begin
      bit_n = 0;
      byte_n++;
    end
    if (bit_n == 8) begin
      sda_oe_n = !(byte_n < 4 && ack_mask[byte_n[1:0]]);
    end else if (byte_n == 1 && rw) begin
      sda_oe_n = READ_BYTE[7 - bit_n];
    end else begin
      sda_oe_n = 1'b1;
    end
  end
endmodule // i2cms_slave_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for i2cms_top: register access and aborted transfers.
// Assumes pull-ups on both wires and the slave model on the data wire.
`timescale 1ns/1ps
`default_nettype none
`include "i2cms_consts.svh"
module tb_top;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] last_rresp;
  logic [1:0] last_bresp;
  logic [3:0] mask = 4'h0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire scl_oe_n, sda_oe_n, slv_oe_n, scl_out, sda_out;
  // Open drain with pull-ups: a released pin reads high
  wire scl = scl_oe_n | scl_out;
  wire sda = (sda_oe_n | sda_out) & slv_oe_n;
  int bad_count = 0;
  int comparisons = 0;
  int lo_cnt = 0;
  int gap = -1;
  int g2;
  logic [31:0] v;
  logic [31:0] st;
  logic [31:0] tgt_c [8] = '{32'h50, 32'h50, 32'h12a5, 32'h12a5, 32'h50,
    32'h2000, 32'h50, 32'h2000};
  logic [31:0] dat_c [8] = '{32'ha5, 32'ha5, 32'ha5, 32'ha5, 32'ha5,
    32'ha5, 32'h1a5, 32'h1a5};
  logic [3:0] msk_c [8] = '{4'hf, 4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 4'h1,
    4'hf};
  logic [31:0] exp_c [8] = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h8, 32'h10,
    32'h0, 32'h20};

  always #12.5 mclk = ~mclk;
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  i2cms_top i2cms_top_i (.MCLK(mclk), .RESET_N(reset_n),
    .LINK_CLK(link_clk), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .BUS_CLOCK_PIN_IN(scl), .BUS_CLOCK_PIN_OUT(scl_out),
    .BUS_CLOCK_PIN_OE_N(scl_oe_n), .BUS_DATA_PIN_IN(sda),
    .BUS_DATA_PIN_OUT(sda_out), .BUS_DATA_PIN_OE_N(sda_oe_n));
  i2cms_slave_model i2cms_slave_model_i (.scl(scl), .sda(sda),
    .ack_mask(mask), .sda_oe_n(slv_oe_n));

  // Length of the first clock-low phase of each frame, in link cycles
  always @(posedge link_clk) begin
    if (!scl_oe_n) lo_cnt++;
    else begin
      if (lo_cnt != 0 && gap < 0) gap = lo_cnt;
      lo_cnt = 0;
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    last_rresp = rresp;
    rready <= 1'b0;
  endtask
  // Starts one transfer and polls until it reports done
  task automatic run(input logic [31:0] t, input logic [31:0] d,
    input logic [3:0] m, output logic [31:0] s);
    mask = m;
    gap = -1;
    wr(`I2CMS_OFF_TARGET, t);
    wr(`I2CMS_OFF_DATA, d);
    wr(`I2CMS_OFF_CTRL, 32'h1);
    do rd(`I2CMS_OFF_STATUS, s);
    while (s[0] !== 1'b0 || s[1] !== 1'b1);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`I2CMS_OFF_SETUP, v);
    check(v, 32'h64);
    rd(`I2CMS_OFF_ABORT, v);
    check(v, 32'h0);
    wr(`I2CMS_OFF_SETUP, 32'hffffffff);
    rd(`I2CMS_OFF_SETUP, v);
    check(v, 32'hff);
    wstrb <= 4'he;
    wr(`I2CMS_OFF_SETUP, 32'h0);
    wstrb <= 4'hf;
    rd(`I2CMS_OFF_SETUP, v);
    check(v, 32'hff);
    rd(8'h00, v);
    check(v, 32'h0);
    check({30'h0, last_rresp}, {30'h0, `I2CMS_RESP_SLVERR});
    wr(8'h00, 32'h0);
    check({30'h0, last_bresp}, {30'h0, `I2CMS_RESP_SLVERR});
    wr(`I2CMS_OFF_SETUP, 32'h2);
    for (int i = 0; i < 8; i++) begin
      run(tgt_c[i], dat_c[i], msk_c[i], st);
      if (i == 0) g2 = gap;
      rd(`I2CMS_OFF_ABORT, v);
      check(v, exp_c[i]);
      check({31'h0, st[2]}, {31'h0, |exp_c[i]});
      check({24'h0, st[15:8]}, (i == 6) ? 32'h3c : 32'h0);
    end
    wr(`I2CMS_OFF_ABORT, 32'h0);
    check({30'h0, last_bresp}, {30'h0, `I2CMS_RESP_OKAY});
    rd(`I2CMS_OFF_ABORT, v);
    check(v, 32'h20);
    wr(`I2CMS_OFF_SETUP, 32'ha);
    run(tgt_c[0], dat_c[0], 4'hf, st);
    check(32'(gap - g2), 32'h8);
    finish_test();
  end
  initial begin
    #(25 * 90000);
    bad_count++;
    finish_test();
  end
endmodule // tb_top

bind i2cms_top i2cms_asserts i2cms_asserts_i (.MCLK(MCLK),
  .RESET_N(RESET_N), .LINK_CLK(LINK_CLK), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .BUS_CLOCK_PIN_OE_N(BUS_CLOCK_PIN_OE_N),
  .BUS_DATA_PIN_OE_N(BUS_DATA_PIN_OE_N));
`default_nettype wire
